// [shared/cgu_consts.vh]
// Constants for the clock generation and power control block
`ifndef CGU_CONSTS_VH
`define CGU_CONSTS_VH
// Power mode encodings (two-bit mode select)
`define CGU_MODE_NORMAL 2'h0
`define CGU_MODE_BURST 2'h1
`define CGU_MODE_DOZE 2'h2
`define CGU_MODE_SLEEP 2'h3
// Divider select widths and reset values
`define CGU_DIV_W 3
`define CGU_DMA_DIV_RST 3'h0
`define CGU_SYS_DIV_RST 3'h0
`define CGU_DISP_DIV_RST 3'h2
// Burst width field: CPU clock pulses allowed per 32-slot window
`define CGU_BURST_W 5
`define CGU_BURST_RST 5'h1f
// Position of the alternate-function select bit for the clock-out pin
`define CGU_CLKO_SEL_BIT 2
`endif

// [rtl/cgu_clock_unit.v]
// Clock generation unit with power-mode gating and clock-out pin control
//
// Function
// - Four output clocks: reference, DMA/display, system and display reference.
// - Low-frequency reference goes to nearly all modules, power control and RTC.
// - DMA/display clock sources system and display clocks, and clocks display DMA.
// - System clock drives CPU, timers, serial ports and memory controller.
// - Display reference clock goes only to the display controller.
// - DMA/display, system and display reference clocks each have their own programmable frequency; the CPU clock is the gated system clock.
// - CPU clock pulses delivered in bursts of reduced width to save power.
// - Four distinct power modes select different levels of clock activity.
// - Sleep stops every generated clock except the low-frequency reference.
// - Only system clock reaches clock-out pin, when enabled and select bit clear.
`include "cgu_consts.vh"

module cgu_clock_unit (
   // Clock and reset
   input wire clk_i,
   input wire arst_n_i,
   // Low-frequency reference from the crystal oscillator
   input wire ref_clk_i,
   // Frequency selects, divide by 2**(sel+1)
   input wire [`CGU_DIV_W-1:0] dma_div_i,
   input wire [`CGU_DIV_W-1:0] sys_div_i,
   input wire [`CGU_DIV_W-1:0] disp_div_i,
   // Power control
   input wire [1:0] power_mode_i,
   input wire [`CGU_BURST_W-1:0] burst_width_i,
   // Clock-out pin control
   input wire clko_en_i,
   input wire [7:0] port_sel_i,
   // Generated clocks
   output wire low_freq_ref_clock_o,
   output reg dma_display_clock_o,
   output reg system_clock_o,
   output reg display_ref_clock_o,
   output reg cpu_clock_o,
   // Clock-out pin
   output reg clock_out_pin_o,
   output reg clock_out_pin_oe_n_o,
   // Current power mode as applied
   output reg [1:0] mode_active_o
);

   // Power mode states, one-hot
   localparam ST_NORMAL = 4'h1;
   localparam ST_BURST = 4'h2;
   localparam ST_DOZE = 4'h4;
   localparam ST_SLEEP = 4'h8;

   reg [3:0] state;
   reg [3:0] next_state;
   reg [7:0] dma_cnt;
   reg [7:0] sys_cnt;
   reg [7:0] disp_cnt;
   reg dma_tick;
   reg [4:0] burst_slot;
   reg sys_gate;
   reg cpu_gate;
   reg disp_gate;
   reg dma_gate;

   // Terminal count test for a toggle divider, one toggle every 2**sel counts
   function div_hit;
      input [7:0] cnt;
      input [`CGU_DIV_W-1:0] sel;
      begin
         div_hit = (cnt >= ((8'h1 << sel) - 8'h1));
      end
   endfunction

   // Derived clocks may run in every state but sleep
   function clk_run;
      input [3:0] st;
      begin
         clk_run = ~st[3];
      end
   endfunction

   // The CPU sees pulses only in normal and burst; doze and sleep close it
   function cpu_run;
      input [3:0] st;
      begin
         cpu_run = st[0] | st[1];
      end
   endfunction

   // Reference passes straight through; never gated
   assign low_freq_ref_clock_o = ref_clk_i;

   always @* begin
      next_state = state;
      case (power_mode_i)
         `CGU_MODE_NORMAL: next_state = ST_NORMAL;
         `CGU_MODE_BURST: next_state = ST_BURST;
         `CGU_MODE_DOZE: next_state = ST_DOZE;
         `CGU_MODE_SLEEP: next_state = ST_SLEEP;
         default: next_state = ST_NORMAL;
      endcase
   end

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ST_NORMAL;
         mode_active_o <= `CGU_MODE_NORMAL;
      end else begin
         state <= next_state;
         case (next_state)
            ST_BURST: mode_active_o <= `CGU_MODE_BURST;
            ST_DOZE: mode_active_o <= `CGU_MODE_DOZE;
            ST_SLEEP: mode_active_o <= `CGU_MODE_SLEEP;
            default: mode_active_o <= `CGU_MODE_NORMAL;
         endcase
      end
   end

   // DMA/display clock, the root of the two derived clocks
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dma_cnt <= 8'h00;
         dma_display_clock_o <= 1'b0;
         dma_tick <= 1'b0;
         dma_gate <= 1'b1;
      end else begin
         dma_tick <= 1'b0;
         // Gate changes only while the clock is low, so no pulse is cut.
         // The root keeps running until both derived clocks have fallen,
         // otherwise a derived clock caught high would stay high in sleep.
         if (!dma_display_clock_o)
            dma_gate <= clk_run(state) | system_clock_o | display_ref_clock_o;
         if (div_hit(dma_cnt, dma_div_i)) begin
            dma_cnt <= 8'h00;
            dma_tick <= 1'b1;
            if (dma_display_clock_o)
               dma_display_clock_o <= 1'b0;
            else if (dma_gate)
               dma_display_clock_o <= 1'b1;
         end else begin
            dma_cnt <= dma_cnt + 8'h01;
         end
      end
   end

   // Gates follow the mode on every edge. They are consulted only when a
   // clock is about to rise, so a change never cuts a pulse under way, and
   // a clock that is low when sleep ends can always start again.
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_gate <= 1'b1;
         disp_gate <= 1'b1;
      end else begin
         sys_gate <= clk_run(state);
         disp_gate <= clk_run(state);
      end
   end

   // System and CPU clocks advance only on DMA clock rising ticks
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_cnt <= 8'h00;
         system_clock_o <= 1'b0;
         cpu_clock_o <= 1'b0;
         cpu_gate <= 1'b1;
         burst_slot <= 5'h00;
      end else if (dma_tick && dma_display_clock_o) begin
         if (div_hit(sys_cnt, sys_div_i)) begin
            sys_cnt <= 8'h00;
            if (system_clock_o) begin
               system_clock_o <= 1'b0;
               cpu_clock_o <= 1'b0;
               burst_slot <= burst_slot + 5'h01;
               // Burst: pass burst_width slots of every 32
               cpu_gate <= state[0] | (state[1] & (burst_slot < burst_width_i));
            end else if (sys_gate) begin
               system_clock_o <= 1'b1;
               // Mode rechecked here so doze holds from the next whole pulse
               cpu_clock_o <= cpu_gate & cpu_run(state);
            end
         end else begin
            sys_cnt <= sys_cnt + 8'h01;
         end
      end
   end

   // Display reference clock, also stepped by DMA clock rising ticks
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         disp_cnt <= 8'h00;
         display_ref_clock_o <= 1'b0;
      end else if (dma_tick && dma_display_clock_o) begin
         if (div_hit(disp_cnt, disp_div_i)) begin
            disp_cnt <= 8'h00;
            if (display_ref_clock_o)
               display_ref_clock_o <= 1'b0;
            else if (disp_gate)
               display_ref_clock_o <= 1'b1;
         end else begin
            disp_cnt <= disp_cnt + 8'h01;
         end
      end
   end

   // Clock-out pin: system clock only, enable set and select bit clear
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clock_out_pin_o <= 1'b0;
         clock_out_pin_oe_n_o <= 1'b1;
      end else begin
         clock_out_pin_oe_n_o <= ~(clko_en_i & ~port_sel_i[`CGU_CLKO_SEL_BIT]);
         clock_out_pin_o <= system_clock_o;
      end
   end

endmodule

// [bench/cgu_checker.sv]
// Port assertions for the clock unit
`include "cgu_consts.vh"
module cgu_checker (
   input wire clk_i,
   input wire arst_n_i,
   input wire ref_clk_i,
   input wire [1:0] power_mode_i,
   input wire clko_en_i,
   input wire [7:0] port_sel_i,
   input wire low_freq_ref_clock_o,
   input wire system_clock_o,
   input wire cpu_clock_o,
   input wire clock_out_pin_o,
   input wire clock_out_pin_oe_n_o,
   input wire [1:0] mode_active_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   wire pin_on = clko_en_i && !port_sel_i[`CGU_CLKO_SEL_BIT];
   sequence s_sleep; (mode_active_o == `CGU_MODE_SLEEP) [*8] ##0 !system_clock_o; endsequence
   sequence s_doze; (mode_active_o == `CGU_MODE_DOZE) [*8] ##0 !system_clock_o; endsequence
   a_ref_pass: assert property (low_freq_ref_clock_o == ref_clk_i)
      else $error("ref differs");
   a_mode_follow: assert property (mode_active_o == $past(power_mode_i))
      else $error("mode lag");
   a_sleep_stop: assert property (s_sleep |=> !system_clock_o && !cpu_clock_o)
      else $error("sleep leak");
   a_doze_cpu: assert property (s_doze |=> !cpu_clock_o)
      else $error("doze cpu");
   a_cpu_subset: assert property (cpu_clock_o |-> system_clock_o)
      else $error("cpu alone");
   a_sys_whole: assert property ($rose(system_clock_o) |=> system_clock_o)
      else $error("short pulse");
   a_pin_copy: assert property ($past(pin_on) |-> clock_out_pin_o == $past(system_clock_o))
      else $error("pin data");
   a_pin_drive: assert property (clock_out_pin_oe_n_o == !$past(pin_on))
      else $error("pin enable");
endmodule
bind cgu_clock_unit cgu_checker i_chk (.clk_i, .arst_n_i, .ref_clk_i, .power_mode_i,
   .clko_en_i, .port_sel_i, .low_freq_ref_clock_o, .system_clock_o, .cpu_clock_o,
   .clock_out_pin_o, .clock_out_pin_oe_n_o, .mode_active_o);

// [bench/cgu_periph_model.sv]
// Peripheral side: counts the clock pulses it is given
module cgu_periph_model (
   input wire sys_clk_i,
   input wire cpu_clk_i,
   input wire disp_clk_i,
   output int n_sys_o,
   output int n_cpu_o,
   output int n_disp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge sys_clk_i) n_sys_o++;
   always @(posedge cpu_clk_i) n_cpu_o++;
   always @(posedge disp_clk_i) n_disp_o++;
endmodule

// [bench/clock_generation_power_control_tb_top.sv]
// Self-checking bench for the clock unit
`include "cgu_consts.vh"
module clock_generation_power_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, arst_n_i = 0, ref_clk_i = 0, clko_en_i = 0;
   logic [2:0] dma_div_i = 0, sys_div_i = 0, disp_div_i = 0;
   logic [1:0] power_mode_i = 0;
   logic [4:0] burst_width_i = 5'h1f;
   logic [7:0] port_sel_i = 0;
   wire dma, sys, disp, cpu, pin, oe_n, lf;
   wire [1:0] mode;
   int n_errors = 0, checked = 0, ns, nc, nd, p, c;
   cgu_clock_unit i_dut (.clk_i, .arst_n_i, .ref_clk_i, .dma_div_i, .sys_div_i, .disp_div_i,
      .power_mode_i, .burst_width_i, .clko_en_i, .port_sel_i, .low_freq_ref_clock_o(lf),
      .dma_display_clock_o(dma), .system_clock_o(sys), .display_ref_clock_o(disp),
      .cpu_clock_o(cpu), .clock_out_pin_o(pin), .clock_out_pin_oe_n_o(oe_n), .mode_active_o(mode));
   cgu_periph_model i_per (.sys_clk_i(sys), .cpu_clk_i(cpu), .disp_clk_i(disp),
      .n_sys_o(ns), .n_cpu_o(nc), .n_disp_o(nd));
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Rise-to-rise span in clk cycles: root period 2*2**a, derived 2*2**b roots
   function automatic int exp_per(input int a, input int b);
      return 4 << (a + b);
   endfunction
   task close_out;
      if (n_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Cycles between rises; early passes skip the settling after a divider change
   task per(input bit k);
      for (int i = 0; i < 3; i++) begin
         c = k ? nd : ns;
         p = 0;
         while ((k ? nd : ns) == c) begin
            @(posedge clk_i);
            p++;
         end
      end
   endtask
   initial forever #20 clk_i = ~clk_i;
   initial begin
      #2;
      forever #160 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      #3_000_000;
      n_errors++;
      close_out;
   end
   initial begin
      void'($urandom(32'he074));
      repeat (8) @(posedge clk_i);
      cmp({dma, sys, disp, cpu, oe_n, mode}, 7'h04);
      #2 arst_n_i = 1;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         #2 dma_div_i = 3'($urandom % 3);
         sys_div_i = 3'($urandom % 3);
         disp_div_i = 3'($urandom % 3);
         per(0);
         cmp(p, exp_per(dma_div_i, sys_div_i));
         per(1);
         cmp(p, exp_per(dma_div_i, disp_div_i));
      end
      for (int j = 0; j < 5; j++) begin
         @(posedge clk_i);
         #2 power_mode_i = j < 3 ? `CGU_MODE_BURST : j == 3 ? `CGU_MODE_NORMAL : `CGU_MODE_DOZE;
         burst_width_i = j == 0 ? 5'h00 : j == 1 ? 5'h1f : 5'($urandom);
         repeat (300) @(posedge clk_i);
         p = ns + 32;
         c = nc;
         while (ns < p) @(posedge clk_i);
         cmp(nc - c, j < 3 ? burst_width_i : j == 3 ? 32 : 0);
      end
      #2 power_mode_i = `CGU_MODE_SLEEP;
      repeat (300) @(posedge clk_i);
      c = ns + nc + nd;
      repeat (300) @(posedge clk_i);
      cmp(ns + nc + nd, c);
      cmp(lf, ref_clk_i);
      #2 power_mode_i = `CGU_MODE_NORMAL;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         #2 clko_en_i = k[0];
         port_sel_i = {5'($urandom), k[1], 2'($urandom)};
         repeat (2) @(posedge clk_i);
         cmp(oe_n, !(k[0] && !k[1]));
      end
      close_out;
   end
endmodule
